/* File: dv/ivps_bench.sv */
// Bench joining device and core ends, checked against an integer model.
// Assumes a 50 MHz clock and a shortened watchdog count.
`timescale 1ns/1ps
module ivps_bench;
  import ivps_pkg::*;
  localparam int WD = 200;
  logic clk_sys = 0, sys_rst = 1, wr = 0, rd = 0, nmi_taken, ram_chip_enable_n, rst_seen = 0;
  logic power_fail_in_n = 1, supply_good_in = 1, above_battery_in = 1, pfail_enable = 1;
  logic watchdog_enable = 0, watchdog_kick_in = 0, decoded_ram_select_n = 1;
  logic [8:0] src_in = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, rdata, nmi_target, rv;
  logic [7:0] pg;
  int n_mismatch = 0, checks = 0, pend, en, idx, i, n;
  ivps_if lk();
  ivps_device #(.WDOG_CYCLES(WD)) ivps_device_i(.clk_sys, .sys_rst, .bus(lk), .src_in,
    .power_fail_in_n, .supply_good_in, .above_battery_in, .pfail_enable, .watchdog_enable,
    .watchdog_kick_in, .decoded_ram_select_n, .ram_chip_enable_n);
  ivps_core ivps_core_i(.clk_sys, .sys_rst, .bus(lk), .addr, .wdata, .wr, .rd, .rdata,
    .nmi_taken, .nmi_target);
  ivps_monitor ivps_monitor_i(.clk_sys, .sys_rst, .req_pending(lk.req_pending),
    .int_req(lk.int_req), .vector_addr(lk.vector_addr), .int_ack(lk.int_ack),
    .enable_mask(lk.enable_mask), .page_base(lk.page_base), .nmi_pulse(lk.nmi_pulse),
    .power_fail_out_n(lk.power_fail_out_n), .supervisor_status_input(lk.supervisor_status_input),
    .watchdog_cause_out_n(lk.watchdog_cause_out_n), .sys_reset_n(lk.sys_reset_n));
  // Clock and reset-pulse catcher
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!sys_rst && lk.sys_reset_n === 1'b0) rst_seen <= 1'b1;
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e, string m);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pf_check(logic e);
    rd_reg(HREG_STATUS);
    chk(16'(rv[1:0]), {14'h0000, e, e}, "status");
    wr_reg(HREG_IOACC, POWER_FAIL_READ_ADDR);
    repeat (3) tick();
    rd_reg(HREG_IOACC);
    chk(16'(rv[6]), 16'(e), "port bit");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    rv = 16'($urandom(71));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) tick();
    pend = $urandom & 'h1FF | 'h101;
    en = $urandom & 'h1FF | 'h101;
    pg = 8'($urandom);
    wr_reg(HREG_ENABLE, 16'(en));
    wr_reg(HREG_PAGE, {8'h00, pg});
    @(posedge clk_sys);
    src_in <= 9'(pend);
    @(posedge clk_sys);
    src_in <= 9'h000;
    repeat (5) tick();
    rd_reg(HREG_PENDING);
    chk(rv, 16'(pend), "pending");
    while ((pend & en) != 0) begin
      idx = 0;
      while (!pend[idx] || !en[idx]) idx++;
      chk(lk.vector_addr, {pg, 8'(2 * idx)}, "vector");
      wr_reg(HREG_ACK, 16'h0000);
      repeat (3) tick();
      pend &= ~(1 << idx);
      rd_reg(HREG_PENDING);
      chk(rv, 16'(pend), "after ack");
    end
    chk(16'(lk.int_req), 16'h0000, "masked idle");
    $display("test vectors done");
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk_sys);
      pfail_enable <= k[0];
      power_fail_in_n <= 1'b0;
      n = 0;
      repeat (30) begin
        tick();
        if (nmi_taken === 1'b1) n++;
      end
      chk(16'(n), 16'(k), "nmi count");
      pf_check(1'b0);
      @(posedge clk_sys);
      power_fail_in_n <= 1'b1;
      repeat (6) tick();
      pf_check(1'b1);
    end
    chk(nmi_target, POWER_FAIL_JUMP_VECTOR, "jump target");
    $display("test power fail done");
    @(posedge clk_sys);
    watchdog_enable <= 1'b1;
    rst_seen <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      repeat (120) @(posedge clk_sys);
      if (k[0]) watchdog_kick_in <= ~watchdog_kick_in;
      else wr_reg(HREG_IOACC, WATCHDOG_KICK_ADDR);
    end
    #1 chk(16'(rst_seen), 16'h0000, "early reset");
    for (i = 0; i < 400 && rst_seen !== 1'b1; i++) tick();
    chk(16'(rst_seen), 16'h0001, "watchdog reset");
    chk(16'(lk.watchdog_cause_out_n), 16'h0000, "cause");
    $display("test watchdog done");
    @(posedge clk_sys);
    watchdog_enable <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {supply_good_in, above_battery_in, decoded_ram_select_n} <= 3'(k);
      repeat (4) tick();
      chk(16'(ram_chip_enable_n), 16'(k[0] || !(k[2] && k[1])), "ram enable");
      chk(16'(lk.sys_reset_n), 16'(k[2]), "supply reset");
    end
    chk(16'(lk.watchdog_cause_out_n), 16'h0001, "power-on cause");
    $display("test supply done");
    stop_test();
  end
endmodule

/* File: dv/ivps_monitor.sv */
// Checker for the link between the device and core ends.
// Assumes it is fed the signals of the one bench link.
`timescale 1ns/1ps
module ivps_monitor (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset, high
  input wire logic [8:0] req_pending, // Pending flags
  input wire logic int_req, // Request level
  input wire logic [15:0] vector_addr, // Table address
  input wire logic int_ack, // Acknowledge
  input wire logic [8:0] enable_mask, // Enables
  input wire logic [7:0] page_base, // Page register
  input wire logic nmi_pulse, // Nonmaskable pulse
  input wire logic power_fail_out_n, // Fail level
  input wire logic supervisor_status_input, // Status bit
  input wire logic watchdog_cause_out_n, // Cause flag
  input wire logic sys_reset_n // Reset to core
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Request and vector selection
  a_req_level: assert property (int_req == |(req_pending & enable_mask))
    else $error("request level wrong");
  a_vec_page: assert property (int_req |-> vector_addr[15:8] == page_base)
    else $error("vector page wrong");
  a_vec_top: assert property (int_req && req_pending[0] && enable_mask[0]
    |-> vector_addr[7:0] == 8'h00)
    else $error("top source not first");
  a_vec_low: assert property ((req_pending & enable_mask) == 9'h100
    |-> vector_addr[7:0] == 8'h10)
    else $error("lowest offset wrong");
  a_ack_clear: assert property (int_ack && int_req && vector_addr[7:0] == 8'h00
    |=> !req_pending[0])
    else $error("ack left source pending");
  // Power fail and watchdog
  a_nmi_single: assert property (nmi_pulse |=> !nmi_pulse)
    else $error("nmi pulse too long");
  a_status_same: assert property (supervisor_status_input == power_fail_out_n)
    else $error("status differs from fail line");
  a_wd_cause: assert property ($fell(watchdog_cause_out_n) |-> !sys_reset_n || $past(!sys_reset_n))
    else $error("cause fell without reset");
endmodule

/* File: hw/ivps_core.sv */
// Core end: software register port steering the link to the device.
// Assumes software follows the firmware table-load and watchdog duties.
`timescale 1ns/1ps
module ivps_core
  import ivps_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  ivps_if.core bus, // Link to the device end
  input wire logic [3:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  output logic nmi_taken, // Pulse when entering fixed jump target
  output logic [15:0] nmi_target // Latched jump target
);
  logic [8:0] en_q;
  logic [7:0] page_q;
  logic ack_q, io_q;
  logic [15:0] ioaddr_q, last_vec_q, rdata_q, nmi_tgt_q;
  logic nmi_taken_q;
  logic io_seen_q;
  logic [7:0] io_data_q;

  // Software writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_q <= 9'h000;
      page_q <= 8'h00;
      ack_q <= 1'b0;
      io_q <= 1'b0;
      ioaddr_q <= 16'h0000;
    end else begin
      ack_q <= wr && addr == HREG_ACK && bus.int_req;
      io_q <= wr && addr == HREG_IOACC;
      if (wr && addr == HREG_ENABLE) en_q <= wdata[8:0];
      if (wr && addr == HREG_PAGE) page_q <= wdata[7:0];
      if (wr && addr == HREG_IOACC) ioaddr_q <= wdata;
    end
  end

  // Vector latch on ack and nonmaskable entry
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_vec_q <= 16'h0000;
      nmi_tgt_q <= 16'h0000;
      nmi_taken_q <= 1'b0;
    end else begin
      nmi_taken_q <= bus.nmi_pulse;
      if (bus.nmi_pulse) nmi_tgt_q <= bus.nmi_addr;
      if (wr && addr == HREG_ACK && bus.int_req) last_vec_q <= bus.vector_addr;
    end
  end

  // Capture I/O read data in the one cycle it stands
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_seen_q <= 1'b0;
      io_data_q <= 8'h00;
    end else begin
      io_seen_q <= io_q;
      if (io_seen_q) io_data_q <= bus.io_rdata;
    end
  end

  // Read mux, data in cycle after strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) rdata_q <= 16'h0000;
    else if (rd) begin
      unique case (addr)
        HREG_PENDING: rdata_q <= {7'h00, bus.req_pending};
        HREG_ENABLE: rdata_q <= {7'h00, en_q};
        HREG_PAGE: rdata_q <= {8'h00, page_q};
        HREG_STATUS: rdata_q <= {12'h000, bus.watchdog_cause_out_n, bus.sys_reset_n,
                                 bus.power_fail_out_n, bus.supervisor_status_input};
        HREG_IOACC: rdata_q <= {8'h00, io_data_q};
        HREG_LAST_VECTOR: rdata_q <= last_vec_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else rdata_q <= 16'h0000;
  end

  assign bus.enable_mask = en_q;
  assign bus.page_base = page_q;
  assign bus.int_ack = ack_q;
  assign bus.io_access = io_q;
  assign bus.io_addr = ioaddr_q;
  assign rdata = rdata_q;
  assign nmi_taken = nmi_taken_q;
  assign nmi_target = nmi_tgt_q;
endmodule

/* File: hw/ivps_device.sv */
// Device end: supervisor, watchdog, interrupt pending and vectoring.
// Assumes pins arrive asynchronous and pass two flip-flops first.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ivps_device
  import ivps_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WATCHDOG_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  ivps_if.device bus, // Link to the core end
  input wire logic [8:0] src_in, // Raw maskable sources, bit 0 highest
  input wire logic power_fail_in_n, // Raw power-fail comparator, low fail
  input wire logic supply_good_in, // Supply above reset threshold
  input wire logic above_battery_in, // Supply above battery level
  input wire logic pfail_enable, // Power-fail source strap
  input wire logic watchdog_enable, // Watchdog strap
  input wire logic watchdog_kick_in, // Raw watchdog kick pin
  input wire logic decoded_ram_select_n, // Decoded RAM select, low
  output logic ram_chip_enable_n // RAM chip enable, low
);
  // Two-flop synchroniser stages, one pair per pin
  logic [8:0] src_s1_q, src_s2_q;
  logic pf_s1_q, pf_s2_q;
  logic good_s1_q, good_s2_q;
  logic batt_s1_q, batt_s2_q;
  logic ramsel_s1_q, ramsel_s2_q;
  logic kick_s1_q, kick_s2_q;
  logic pfen_s1_q, pfen_s2_q;
  logic wden_s1_q, wden_s2_q;
  // Edge history
  logic [8:0] src_prev_q;
  logic pf_prev_q, kick_prev_q;
  // Interrupt state
  logic [8:0] pend_q;
  wire logic [8:0] src_rise;
  wire logic [8:0] served;
  logic [3:0] sel;
  logic any;
  logic nmi_q;
  // Watchdog state
  logic [31:0] wd_cnt_q;
  logic wd_reset_q, wd_cause_q, wd_kick;
  // I/O read return
  logic [7:0] rdata_q;

  // Priority encoder, lowest index wins
  function automatic logic [3:0] first_set(input logic [8:0] v);
    first_set = 4'hF;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) first_set = 4'(i);
    end
  endfunction

  // Address match of an I/O access strobe
  function automatic logic io_hit(input logic acc, input logic [15:0] a, input logic [15:0] m);
    io_hit = acc && (a == m);
  endfunction

  // Source synchronisers; no reset, they settle while reset is held
  always_ff @(posedge clk_sys) begin
    src_s1_q <= src_in;
    src_s2_q <= src_s1_q;
  end

  // Supervisor pin synchronisers, each line on its own chain
  always_ff @(posedge clk_sys) begin
    pf_s1_q <= power_fail_in_n;
    pf_s2_q <= pf_s1_q;
    good_s1_q <= supply_good_in;
    good_s2_q <= good_s1_q;
    batt_s1_q <= above_battery_in;
    batt_s2_q <= batt_s1_q;
    ramsel_s1_q <= decoded_ram_select_n;
    ramsel_s2_q <= ramsel_s1_q;
  end

  // Watchdog pin, watchdog strap and power-fail strap synchronisers
  always_ff @(posedge clk_sys) begin
    kick_s1_q <= watchdog_kick_in;
    kick_s2_q <= kick_s1_q;
    pfen_s1_q <= pfail_enable;
    pfen_s2_q <= pfen_s1_q;
    wden_s1_q <= watchdog_enable;
    wden_s2_q <= wden_s1_q;
  end

  // Edge history; reset values match the idle level of each line
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_prev_q <= 9'h000;
      pf_prev_q <= 1'b1;
      kick_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_s2_q;
      pf_prev_q <= pf_s2_q;
      kick_prev_q <= kick_s2_q;
    end
  end

  // Per-source rising edge and service decode
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    assign src_rise[g] = src_s2_q[g] && !src_prev_q[g];
    assign served[g] = bus.int_ack && any && (sel == 4'(g));
  end

  // Pending flags: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_q <= 9'h000;
    end else begin
      pend_q <= src_rise | (pend_q & ~served);
    end
  end

  // Highest enabled pending source is offered to the core
  assign any = |(pend_q & bus.enable_mask);
  assign sel = first_set(pend_q & bus.enable_mask);

  // Link outputs for the maskable path
  assign bus.req_pending = pend_q;
  assign bus.int_req = any;
  // Table entry at page base plus two-byte step offset
  assign bus.vector_addr = {bus.page_base, 8'(ATTENTION_VECTOR + VECTOR_STEP * sel)};
  assign bus.nmi_addr = POWER_FAIL_JUMP_VECTOR;

  // Nonmaskable pulse on the falling fail edge only, well inside the entry bound
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= pfen_s2_q && pf_prev_q && !pf_s2_q;
    end
  end
  assign bus.nmi_pulse = nmi_q;
  // Fail level to the core, as status bit and as fail line
  assign bus.power_fail_out_n = pf_s2_q;
  assign bus.supervisor_status_input = pf_s2_q;

  // Kick on either pin edge or on an access to the kick address
  assign wd_kick = (kick_prev_q != kick_s2_q) ||
                   io_hit(bus.io_access, bus.io_addr, WATCHDOG_KICK_ADDR);

  // Watchdog counter; a disabled strap holds it at zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst || wd_reset_q || !wden_s2_q) begin
      wd_cnt_q <= 32'h0000_0000;
    end else if (wd_kick) begin
      wd_cnt_q <= 32'h0000_0000;
    end else begin
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
    end
  end

  // One-cycle watchdog reset pulse when the count runs out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_reset_q <= 1'b0;
    end else begin
      wd_reset_q <= wden_s2_q && wd_cnt_q == 32'(WDOG_CYCLES - 1);
    end
  end

  // Reset cause: watchdog marks low, only a supply drop or sys_rst marks high again
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wd_cause_q <= 1'b1;
    end else if (wd_reset_q) begin
      wd_cause_q <= 1'b0;
    end else if (!good_s2_q) begin
      wd_cause_q <= 1'b1;
    end
  end
  assign bus.watchdog_cause_out_n = wd_cause_q;

  // Reset to the core while the supply is below threshold or the watchdog fires
  assign bus.sys_reset_n = good_s2_q && !wd_reset_q && !sys_rst;
  // RAM select passes only while supply is above threshold and battery
  assign ram_chip_enable_n = ramsel_s2_q | ~(good_s2_q & batt_s2_q);

  // Fail level on the read return, one cycle after the access
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (io_hit(bus.io_access, bus.io_addr, POWER_FAIL_READ_ADDR)) begin
      rdata_q <= 8'(pf_s2_q) << POWER_FAIL_READ_BIT;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign bus.io_rdata = rdata_q;
endmodule

/* File: hw/ivps_if.sv */
// Interface joining the supervisor/interrupt device and the processor core end.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface ivps_if;
  logic [8:0] req_pending; // Pending maskable sources, bit 0 highest
  logic int_req; // Maskable interrupt request level
  logic [15:0] vector_addr; // Handler table address for the request
  logic int_ack; // Core acknowledges the current request, pulse
  logic [8:0] enable_mask; // Core-side enables per source
  logic [7:0] page_base; // Interrupt page register
  logic nmi_pulse; // Nonmaskable request, one-cycle pulse
  logic [15:0] nmi_addr; // Fixed jump target
  logic power_fail_out_n; // Power-fail line level, low means fail
  logic supervisor_status_input; // Status word bit 0 level
  logic io_access; // I/O access strobe from core
  logic [15:0] io_addr; // I/O address
  logic [7:0] io_rdata; // I/O read data, one cycle later
  logic watchdog_cause_out_n; // Low after watchdog reset
  logic sys_reset_n; // System reset to core, low active
  modport device (input int_ack, enable_mask, page_base, io_access, io_addr,
    output req_pending, int_req, vector_addr, nmi_pulse, nmi_addr, power_fail_out_n,
    supervisor_status_input, io_rdata, watchdog_cause_out_n, sys_reset_n);
  modport core (output int_ack, enable_mask, page_base, io_access, io_addr,
    input req_pending, int_req, vector_addr, nmi_pulse, nmi_addr, power_fail_out_n,
    supervisor_status_input, io_rdata, watchdog_cause_out_n, sys_reset_n);
endinterface

/* File: hw/ivps_pkg.sv */
// Package for the interrupt vector and power supervisor pair.
// Assumes a single 50 MHz system clock shared by both ends.
package ivps_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  // Vector offsets from the vector page base, in two-byte steps
  localparam logic [7:0] ATTENTION_VECTOR = 8'h00;
  localparam logic [7:0] PERIODIC_EXT_VECTOR = 8'h02;
  localparam logic [7:0] TIMER0_VECTOR = 8'h04;
  localparam logic [7:0] TIMER1_VECTOR = 8'h06;
  localparam logic [7:0] DMA0_VECTOR = 8'h08;
  localparam logic [7:0] DMA1_VECTOR = 8'h0A;
  localparam logic [7:0] CLOCKED_SERIAL_VECTOR = 8'h0C;
  localparam logic [7:0] ASYNC0_VECTOR = 8'h0E;
  localparam logic [7:0] ASYNC1_VECTOR = 8'h10;
  localparam logic [7:0] VECTOR_STEP = 8'h02;
  // Fixed jump address for the power-fail nonmaskable entry
  localparam logic [15:0] POWER_FAIL_JUMP_VECTOR = 16'h0066;
  // I/O addresses
  localparam logic [15:0] WATCHDOG_KICK_ADDR = 16'h01C0;
  localparam logic [15:0] POWER_FAIL_READ_ADDR = 16'h0111;
  localparam int unsigned POWER_FAIL_READ_BIT = 6;
  localparam int unsigned SUPERVISOR_STATUS_BIT = 0;
  // Watchdog period and handler entry bound
  localparam int unsigned WATCHDOG_MS = 1000;
  localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_MS * (CLK_HZ / 1000);
  localparam int unsigned NMI_ENTRY_US = 100;
  localparam int unsigned NMI_ENTRY_CYCLES = NMI_ENTRY_US * (CLK_HZ / 1_000_000);
  // Maskable source count
  localparam int unsigned NUM_SRC = 9;
  // Host-side register map (own choice)
  localparam logic [3:0] HREG_PENDING = 4'h0;
  localparam logic [3:0] HREG_ENABLE = 4'h1;
  localparam logic [3:0] HREG_PAGE = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_ACK = 4'h4;
  localparam logic [3:0] HREG_IOACC = 4'h5;
  localparam logic [3:0] HREG_LAST_VECTOR = 4'h6;
endpackage
